// ---- shared/addsub_pkg.sv ----
// Purpose: constants and types for the add/subtract/compare unit
// Assumes: 16-bit instruction word, opcode in bits 15:8
// Notes: register port is AXI4-Lite, 32-bit data
package addsub_pkg;
	localparam logic [7:0] OP_SUM_NO_FLAGS_I4 = 8'hA0;
	localparam logic [7:0] OP_SUM_NO_FLAGS_N4 = 8'hA1;
	localparam logic [7:0] OP_SUM_NO_FLAGS_RR = 8'hA2;
	localparam logic [7:0] OP_ADD_I4 = 8'hA4;
	localparam logic [7:0] OP_ADD_N4 = 8'hA5;
	localparam logic [7:0] OP_ADD_RR = 8'hA6;
	localparam logic [7:0] OP_SUM_WITH_CARRY_IN_RR = 8'hA7;
	localparam logic [7:0] OP_CMP_I4 = 8'hA8;
	localparam logic [7:0] OP_CMP_N4 = 8'hA9;
	localparam logic [7:0] OP_CMP_RR = 8'hAA;
	localparam logic [7:0] OP_SUB_RR = 8'hAC;
	localparam logic [7:0] OP_DIFFERENCE_WITH_BORROW_RR = 8'hAD;
	localparam logic [7:0] OP_DIFFERENCE_NO_FLAGS_RR = 8'hAE;
	localparam logic [7:0] OP_MDREG_HI = 8'hB7;
	// Register byte addresses
	localparam logic [7:0] ADDR_INSTR = 8'h00;
	localparam logic [7:0] ADDR_STATUS = 8'h04;
	localparam logic [7:0] ADDR_FLAGS = 8'h08;
	localparam logic [7:0] ADDR_RESULT = 8'h0C;
	localparam logic [7:0] ADDR_HAZARD = 8'h10;
	localparam logic [7:0] ADDR_REGS = 8'h40;
	localparam logic [3:0] REG_FRAME = 4'h4;
	localparam logic [3:0] REG_THIRTEEN = 4'hD;
	localparam logic [3:0] REG_STACK = 4'hF;
	localparam int FLAG_N = 3;
	localparam int FLAG_Z = 2;
	localparam int FLAG_V = 1;
	localparam int FLAG_C = 0;
	localparam logic [1:0] RESP_OKAY = 2'b00;
	localparam logic [1:0] RESP_SLVERR = 2'b10;
	localparam logic [3:0] FLAGS_RST = 4'h0;
	localparam logic [2:0] EXTRA_STALL = 3'd1;
	localparam logic [2:0] LOAD_STALL = 3'd1;

	typedef enum logic [1:0] {
		ST_IDLE = 2'b00,
		ST_EXEC = 2'b01,
		ST_STALL = 2'b11
	} exec_state_t;

	typedef struct packed {
		logic [1:0] ext; // 0 register, 1 zero-ext, 2 extended with ones
		logic sub;
		logic use_c;
		logic wr_dst;
		logic wr_flags;
		logic valid;
	} op_ctrl_t;

	typedef struct packed {
		logic ld_pending; // last executed was a load toward ld_reg
		logic [3:0] ld_reg;
		logic sp_hazard;
		logic md_hazard;
	} hazard_t;
endpackage

// ---- rtl/add_sub_compare_unit.sv ----
// Purpose: add, subtract and compare execution with interlock timing
// Assumes: instruction words arrive by AXI4-Lite writes
// Notes: register file is local flip-flops, visible over the bus
`timescale 1ns/10ps
module add_sub_compare_unit (
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic [7:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic [7:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	output logic [4:0] imm_s5,
	output logic [31:0] imm_s10,
	output logic [31:0] disp_u6,
	output logic [31:0] dir_addr10,
	output logic [31:0] branch_off9,
	output logic [31:0] postinc_addr,
	input wire logic mem_ready,
	output logic busy
);
	import addsub_pkg::*;

	// ------------------------------------------------------------
	// State
	// ------------------------------------------------------------
	typedef struct packed {
		logic [15:0][31:0] regs;
		logic [3:0] flags;
		logic [31:0] result;
		exec_state_t st;
		logic [15:0] instr;
		logic [2:0] stall_cnt;
		logic [2:0] extra_cnt;
		hazard_t hz;
		logic [7:0] hz_in; // unused; the software-written next-instruction hints land in hz
		logic mem_wait;
		logic aw_got;
		logic w_got;
		logic [7:0] aw_addr;
		logic [31:0] w_data;
		logic [3:0] w_strb;
		logic bvalid;
		logic [1:0] bresp;
		logic rvalid;
		logic [31:0] rdata;
		logic [1:0] rresp;
		logic [31:0] cycles;
		logic [31:0] postinc;
	} unit_state_t;

	unit_state_t s_q;
	unit_state_t s_d;

	// ------------------------------------------------------------
	// Decode helpers
	// ------------------------------------------------------------
	function automatic op_ctrl_t decode(input logic [7:0] op);
		op_ctrl_t c;
		c = '0;
		c.valid = 1'b1;
		case (op)
			OP_ADD_RR: begin c.wr_dst = 1'b1; c.wr_flags = 1'b1; end
			OP_ADD_I4: begin c.ext = 2'd1; c.wr_dst = 1'b1; c.wr_flags = 1'b1; end
			OP_ADD_N4: begin c.ext = 2'd2; c.wr_dst = 1'b1; c.wr_flags = 1'b1; end
			OP_SUM_WITH_CARRY_IN_RR: begin c.use_c = 1'b1; c.wr_dst = 1'b1; c.wr_flags = 1'b1; end
			OP_SUM_NO_FLAGS_RR: begin c.wr_dst = 1'b1; end
			OP_SUM_NO_FLAGS_I4: begin c.ext = 2'd1; c.wr_dst = 1'b1; end
			OP_SUM_NO_FLAGS_N4: begin c.ext = 2'd2; c.wr_dst = 1'b1; end
			OP_SUB_RR: begin c.sub = 1'b1; c.wr_dst = 1'b1; c.wr_flags = 1'b1; end
			OP_DIFFERENCE_NO_FLAGS_RR: begin c.sub = 1'b1; c.wr_dst = 1'b1; end
			OP_DIFFERENCE_WITH_BORROW_RR: begin
				c.sub = 1'b1;
				c.use_c = 1'b1;
				c.wr_dst = 1'b1;
				c.wr_flags = 1'b1;
			end
			OP_CMP_RR: begin c.sub = 1'b1; c.wr_flags = 1'b1; end
			OP_CMP_I4: begin c.sub = 1'b1; c.ext = 2'd1; c.wr_flags = 1'b1; end
			OP_CMP_N4: begin c.sub = 1'b1; c.ext = 2'd2; c.wr_flags = 1'b1; end
			OP_MDREG_HI: begin c.wr_dst = 1'b1; end
			default: c.valid = 1'b0;
		endcase
		return c;
	endfunction

	// Negative 4-bit immediates: field extended with ones, range -16..-1
	function automatic logic [31:0] ext_imm(input logic [1:0] ext, input logic [3:0] f);
		if (ext == 2'd2) begin
			return {28'hFFF_FFFF, f};
		end
		return {28'h000_0000, f};
	endfunction

	// ------------------------------------------------------------
	// Operand ranges for the decoder side
	// ------------------------------------------------------------
	always_comb begin
		imm_s5 = s_q.instr[8:4];
		imm_s10 = {{22{s_q.instr[7]}}, s_q.instr[7:0], 2'b00};
		disp_u6 = {26'h000_0000, s_q.instr[7:4], 2'b00};
		dir_addr10 = {22'h00_0000, s_q.instr[7:0], 2'b00};
		branch_off9 = {{23{s_q.instr[7]}}, s_q.instr[7:0], 1'b0};
		postinc_addr = s_q.postinc;
	end

	// ------------------------------------------------------------
	// Datapath and sequencing
	// ------------------------------------------------------------
	op_ctrl_t ctl;
	logic [3:0] dst_idx;
	logic [3:0] src_idx;
	logic [31:0] a_op;
	logic [31:0] b_op;
	logic [32:0] sum;
	logic [31:0] res;
	logic ld_hit;
	logic [2:0] stall_need;
	logic wr_fire;
	logic rd_fire;
	logic finish;

	always_comb begin
		s_d = s_q;
		ctl = decode(s_q.instr[15:8]);
		dst_idx = s_q.instr[3:0];
		src_idx = s_q.instr[7:4];
		if (s_q.instr[15:8] == OP_MDREG_HI) begin
			dst_idx = REG_THIRTEEN;
		end
		a_op = s_q.regs[dst_idx];
		b_op = (ctl.ext == 2'd0) ? s_q.regs[src_idx] : ext_imm(ctl.ext, s_q.instr[7:4]);
		if (ctl.sub) begin
			sum = {1'b0, a_op} + {1'b0, ~b_op} + {32'h0000_0000, ~(ctl.use_c & s_q.flags[FLAG_C])};
		end else begin
			sum = {1'b0, a_op} + {1'b0, b_op} + {32'h0000_0000, ctl.use_c & s_q.flags[FLAG_C]};
		end
		res = sum[31:0];
		ld_hit = s_q.hz.ld_pending && (s_q.hz.ld_reg == src_idx || s_q.hz.ld_reg == dst_idx);
		stall_need = 3'd0;
		if (ld_hit) begin
			stall_need = LOAD_STALL;
		end else if (s_q.hz.sp_hazard || s_q.hz.md_hazard) begin
			stall_need = EXTRA_STALL;
		end
		wr_fire = s_q.aw_got && s_q.w_got && !s_q.bvalid;
		rd_fire = s_axi_arvalid && !s_q.rvalid;
		finish = 1'b0;
		// Busy cycle count, stalls and ready waits included
		if (s_q.st != ST_IDLE) begin
			s_d.cycles = s_q.cycles + 32'h0000_0001;
		end
		case (s_q.st)
			ST_IDLE: begin
				if (wr_fire && s_q.aw_addr == ADDR_INSTR) begin
					s_d.st = ST_EXEC;
				end
			end
			ST_EXEC: begin
				// Cycle that spots the hazard is the first of two, not an extra one
				if (stall_need != 3'd0) begin
					s_d.stall_cnt = stall_need;
					s_d.st = ST_STALL;
				end else if (!mem_ready) begin
					s_d.mem_wait = 1'b1;
				end else begin
					finish = 1'b1;
				end
			end
			ST_STALL: begin
				if (s_q.stall_cnt > 3'd1) begin
					s_d.stall_cnt = s_q.stall_cnt - 3'd1;
				end else if (!mem_ready) begin
					s_d.mem_wait = 1'b1;
				end else begin
					finish = 1'b1;
				end
			end
			default: s_d.st = ST_IDLE;
		endcase
		// Completion, shared by plain and interlocked instructions
		if (finish) begin
			s_d.mem_wait = 1'b0;
			s_d.stall_cnt = 3'd0;
			s_d.result = res;
			if (ctl.valid && ctl.wr_dst) begin
				s_d.regs[dst_idx] = res;
			end
			if (ctl.valid && ctl.wr_flags) begin
				s_d.flags[FLAG_N] = res[31];
				s_d.flags[FLAG_Z] = (res == 32'h0000_0000);
				s_d.flags[FLAG_V] = (a_op[31] ^ b_op[31] ^ ~ctl.sub) & (a_op[31] ^ res[31]);
				s_d.flags[FLAG_C] = ctl.sub ? ~sum[32] : sum[32];
			end
			s_d.postinc = s_q.regs[dst_idx];
			s_d.hz = '0;
			s_d.st = ST_IDLE;
		end
		// Write channel: address and data taken in either order
		if (s_axi_awvalid && !s_q.aw_got) begin
			s_d.aw_got = 1'b1;
			s_d.aw_addr = s_axi_awaddr;
		end
		if (s_axi_wvalid && !s_q.w_got) begin
			s_d.w_got = 1'b1;
			s_d.w_data = s_axi_wdata;
			s_d.w_strb = s_axi_wstrb;
		end
		if (wr_fire) begin
			s_d.aw_got = 1'b0;
			s_d.w_got = 1'b0;
			s_d.bvalid = 1'b1;
			s_d.bresp = RESP_OKAY;
			if (s_q.aw_addr == ADDR_INSTR) begin
				if (s_q.st == ST_IDLE) begin
					s_d.instr = s_q.w_data[15:0];
				end else begin
					s_d.bresp = RESP_SLVERR;
				end
			end else if (s_q.aw_addr == ADDR_FLAGS) begin
				s_d.flags = s_q.w_data[3:0];
			end else if (s_q.aw_addr == ADDR_HAZARD) begin
				s_d.hz.ld_pending = s_q.w_data[0];
				s_d.hz.ld_reg = s_q.w_data[7:4];
				s_d.hz.sp_hazard = s_q.w_data[1];
				s_d.hz.md_hazard = s_q.w_data[2];
			end else if (s_q.aw_addr >= ADDR_REGS && s_q.aw_addr[1:0] == 2'b00) begin
				s_d.regs[s_q.aw_addr[5:2]] = s_q.w_data;
			end else if (s_q.aw_addr != ADDR_STATUS && s_q.aw_addr != ADDR_RESULT) begin
				s_d.bresp = RESP_SLVERR;
			end
		end
		if (s_q.bvalid && s_axi_bready) begin
			s_d.bvalid = 1'b0;
		end
		if (rd_fire) begin
			s_d.rvalid = 1'b1;
			s_d.rresp = RESP_OKAY;
			if (s_axi_araddr == ADDR_INSTR) begin
				s_d.rdata = {16'h0000, s_q.instr};
			end else if (s_axi_araddr == ADDR_STATUS) begin
				s_d.rdata = {29'h0000_0000, s_q.mem_wait, s_q.st};
			end else if (s_axi_araddr == ADDR_FLAGS) begin
				s_d.rdata = {28'h000_0000, s_q.flags};
			end else if (s_axi_araddr == ADDR_RESULT) begin
				s_d.rdata = s_q.result;
			end else if (s_axi_araddr == ADDR_HAZARD) begin
				s_d.rdata = s_q.cycles;
			end else if (s_axi_araddr >= ADDR_REGS && s_axi_araddr[1:0] == 2'b00) begin
				s_d.rdata = s_q.regs[s_axi_araddr[5:2]];
			end else begin
				s_d.rdata = 32'h0000_0000;
				s_d.rresp = RESP_SLVERR;
			end
		end
		if (s_q.rvalid && s_axi_rready) begin
			s_d.rvalid = 1'b0;
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			s_q <= '0;
		end else begin
			s_q <= s_d;
		end
	end

	// ------------------------------------------------------------
	// Bus outputs
	// ------------------------------------------------------------
	always_comb begin
		s_axi_awready = !s_q.aw_got;
		s_axi_wready = !s_q.w_got;
		s_axi_bvalid = s_q.bvalid;
		s_axi_bresp = s_q.bresp;
		s_axi_arready = !s_q.rvalid;
		s_axi_rvalid = s_q.rvalid;
		s_axi_rdata = s_q.rdata;
		s_axi_rresp = s_q.rresp;
		busy = (s_q.st != ST_IDLE);
	end

	// ------------------------------------------------------------
	// Checks
	// ------------------------------------------------------------
	a_nf_keep: assert property (@(posedge aclk) disable iff (!aresetn)
		(s_q.st == ST_EXEC && mem_ready && s_q.stall_cnt == 3'd0 && !ctl.wr_flags
		&& stall_need == 3'd0) |=> $stable(s_q.flags))
		else $error("flags changed by flag-free op");
	a_cmp_nowrite: assert property (@(posedge aclk) disable iff (!aresetn)
		(s_q.st == ST_EXEC && ctl.valid && !ctl.wr_dst && stall_need == 3'd0
		&& !wr_fire) |=> $stable(s_q.regs))
		else $error("compare wrote a register");
	a_zero_flag: assert property (@(posedge aclk) disable iff (!aresetn)
		(s_q.st == ST_EXEC && mem_ready && ctl.wr_flags && stall_need == 3'd0 && !wr_fire)
		|=> (s_q.flags[FLAG_Z] == (s_q.result == 32'h0000_0000)))
		else $error("zero flag wrong");
	a_neg_flag: assert property (@(posedge aclk) disable iff (!aresetn)
		(s_q.st == ST_EXEC && mem_ready && ctl.wr_flags && stall_need == 3'd0 && !wr_fire)
		|=> (s_q.flags[FLAG_N] == s_q.result[31]))
		else $error("negative flag wrong");
	a_one_cycle: assert property (@(posedge aclk) disable iff (!aresetn)
		(s_q.st == ST_EXEC && mem_ready && stall_need == 3'd0) |=> s_q.st == ST_IDLE)
		else $error("plain op took more than one cycle");
	a_extra_stall: assert property (@(posedge aclk) disable iff (!aresetn)
		(s_q.st == ST_EXEC && !ld_hit && s_q.hz.sp_hazard)
		|=> s_q.st == ST_STALL ##1 (s_q.st == ST_IDLE || s_q.mem_wait))
		else $error("stack interlock not one extra cycle");
	a_md_stall: assert property (@(posedge aclk) disable iff (!aresetn)
		(s_q.st == ST_EXEC && !ld_hit && s_q.hz.md_hazard) |=> s_q.st == ST_STALL)
		else $error("result register interlock missing");
	a_load_stall: assert property (@(posedge aclk) disable iff (!aresetn)
		(s_q.st == ST_EXEC && ld_hit) |=> s_q.st == ST_STALL)
		else $error("load interlock missing");
	a_ready_wait: assert property (@(posedge aclk) disable iff (!aresetn)
		(s_q.st == ST_EXEC && stall_need == 3'd0 && !mem_ready) |=> s_q.st == ST_EXEC)
		else $error("completed without ready");
	a_imm_scale: assert property (@(posedge aclk) disable iff (!aresetn)
		imm_s10[1:0] == 2'b00 && $signed(imm_s10) >= -512 && $signed(imm_s10) <= 508)
		else $error("scaled immediate out of range");
	a_disp_range: assert property (@(posedge aclk) disable iff (!aresetn)
		disp_u6[1:0] == 2'b00 && disp_u6 <= 32'h0000_003C)
		else $error("stack displacement out of range");
	a_dir_range: assert property (@(posedge aclk) disable iff (!aresetn)
		dir_addr10[1:0] == 2'b00 && dir_addr10 <= 32'h0000_03FC)
		else $error("direct address out of range");
	// Alias op must land in register 13 whatever its low field says
	a_alias_dst: assert property (@(posedge aclk) disable iff (!aresetn)
		(s_q.st == ST_EXEC && s_q.instr[15:8] == OP_MDREG_HI && stall_need == 3'd0
		&& mem_ready && !wr_fire) |=> s_q.regs[REG_THIRTEEN] == s_q.result)
		else $error("alias op missed register 13");
	a_min_cycle: assert property (@(posedge aclk) disable iff (!aresetn)
		(s_q.st == ST_IDLE && wr_fire && s_q.aw_addr == ADDR_INSTR) |=> busy)
		else $error("instruction took no cycle");
endmodule // add_sub_compare_unit

// ---- dv/mem_ready_model.sv ----
// Purpose: memory side ready responder for the execution unit
// Assumes: busy marks an instruction in flight
// Notes: slow mode withholds ready for seven cycles per instruction
`timescale 1ns/10ps
module mem_ready_model (
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic busy,
	input wire logic slow,
	output logic mem_ready
);
	logic [2:0] hold_q;
	logic busy_q;
	logic start;
	// ----------------------------------------
	// Wait states
	// ----------------------------------------
	assign start = busy && !busy_q && slow;
	always_ff @(posedge aclk) begin
		busy_q <= busy;
		if (!aresetn) begin
			hold_q <= 3'h0;
		end else if (start) begin
			hold_q <= 3'h6;
		end else if (hold_q != 3'h0) begin
			hold_q <= hold_q - 3'h1;
		end
	end
	// Ready withheld from the first busy cycle, no gap for a race
	assign mem_ready = (hold_q == 3'h0) && !start;
endmodule // mem_ready_model

// ---- dv/add_sub_compare_unit_tb.sv ----
// Purpose: self-checking bench for the add/subtract/compare unit
// Assumes: AXI4-Lite master here, ready model on the memory side
// Notes: operands R3 and R9, flags preset before every op_case instruction
`timescale 1ns/10ps
module add_sub_compare_unit_tb;
	import addsub_pkg::*;
	logic aclk = 0, aresetn = 0, awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
	logic [7:0] awaddr = 8'h00, araddr = 8'h00;
	logic [31:0] wdata = 32'h0000_0000, rdata, imm_s10, disp_u6, dir_addr10, br9, pinc;
	logic [1:0] bresp, rresp;
	logic [4:0] imm_s5;
	logic awready, wready, bvalid, arready, rvalid, mem_ready, busy, slow = 0;
	int error_cnt = 0, n_tests = 0, bc = 0, cyc = 0;
	add_sub_compare_unit u_add_sub_compare_unit (.aclk(aclk), .aresetn(aresetn),
		.s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
		.s_axi_wdata(wdata), .s_axi_wstrb(4'hF), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
		.s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
		.s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
		.s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
		.imm_s5(imm_s5), .imm_s10(imm_s10), .disp_u6(disp_u6), .dir_addr10(dir_addr10),
		.branch_off9(br9), .postinc_addr(pinc), .mem_ready(mem_ready), .busy(busy));
	mem_ready_model u_mem_ready_model (.aclk(aclk), .aresetn(aresetn), .busy(busy),
		.slow(slow), .mem_ready(mem_ready));
	// ----------------------------------------
	// Clock, busy counter, watchdog
	// ----------------------------------------
	initial begin
		forever #25 aclk = ~aclk;
	end
	always @(posedge aclk) begin
		cyc++;
		if (busy === 1'b1) bc++;
		if (cyc == 20000) begin
			error_cnt++;
			close_out();
		end
	end
	// ----------------------------------------
	// Helpers
	// ----------------------------------------
	task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
		n_tests++;
		if (got !== exp) begin
			$display("Error %s expected %h seen %h", nm, exp, got);
			error_cnt++;
		end
	endtask
	task automatic axw(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
		awaddr <= a;
		wdata <= d;
		awvalid <= 1;
		wvalid <= 1;
		bready <= 1;
		forever begin
			@(posedge aclk);
			if (awvalid && awready) awvalid <= 0;
			if (wvalid && wready) wvalid <= 0;
			if (bvalid) begin
				r = bresp;
				bready <= 0;
				break;
			end
		end
		// One quiet edge so a following call never rewrites bready at once
		@(posedge aclk);
	endtask
	task automatic axr(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
		araddr <= a;
		arvalid <= 1;
		rready <= 1;
		forever begin
			@(posedge aclk);
			if (arvalid && arready) arvalid <= 0;
			if (rvalid) begin
				d = rdata;
				r = rresp;
				rready <= 0;
				break;
			end
		end
		@(posedge aclk);
	endtask
	task automatic exec(input logic [15:0] ins, output int n);
		logic [1:0] r;
		bc = 0;
		axw(ADDR_INSTR, {16'h0000, ins}, r);
		for (int i = 0; i < 40; i++) begin
			if (bc > 0 && busy === 1'b0) break;
			@(posedge aclk);
		end
		n = bc;
	endtask
	// ----------------------------------------
	// Scenarios
	// ----------------------------------------
	task automatic op_case(input logic [7:0] op, input logic [5:0] at, input logic [31:0] a,
			input logic [3:0] f);
		logic [31:0] b, rr, d;
		logic [1:0] rs;
		logic c, v;
		int n;
		b = (at[4:3] == 2'd0) ? 32'h8000_0009 : {(at[4:3] == 2'd2) ? 28'hFFF_FFFF : 28'h0, 4'h9};
		if (at[5]) {c, rr} = {1'b0, a} - {1'b0, b} - (at[2] & f[0]);
		else {c, rr} = {1'b0, a} + {1'b0, b} + (at[2] & f[0]);
		v = (rr[31] != a[31]) && ((a[31] == b[31]) ^ at[5]);
		axw(ADDR_REGS + 8'h0C, a, rs);
		axw(ADDR_REGS + 8'h24, 32'h8000_0009, rs);
		axw(ADDR_FLAGS, {28'h0, f}, rs);
		exec({op, 8'h93}, n);
		chk("cycles", 1, n);
		axr(ADDR_REGS + 8'h0C, d, rs);
		chk("dst", at[1] ? rr : a, d);
		axr(ADDR_FLAGS, d, rs);
		chk("flags", {28'h0, at[0] ? {rr[31], rr == 0, v, c} : f}, d);
		chk("postinc", a, pinc);
	endtask
	task automatic hz(input logic [31:0] hint, input int exp);
		logic [1:0] rs;
		int n;
		axw(ADDR_HAZARD, hint, rs);
		exec({OP_ADD_RR, 8'h93}, n);
		chk("stall", exp, n);
	endtask
	task automatic close_out();
		$display("comparisons %0d mismatches %0d", n_tests, error_cnt);
		if (error_cnt == 0 && n_tests > 0) $display("NO MISMATCHES");
		else $display("MISMATCHES SEEN");
		$finish;
	endtask
	// ----------------------------------------
	// Main sequence
	// ----------------------------------------
	localparam logic [7:0] OPS [13] = '{OP_SUM_NO_FLAGS_I4, OP_SUM_NO_FLAGS_N4, OP_SUM_NO_FLAGS_RR, OP_ADD_I4,
		OP_ADD_N4, OP_ADD_RR, OP_SUM_WITH_CARRY_IN_RR, OP_CMP_I4, OP_CMP_N4, OP_CMP_RR, OP_SUB_RR,
		OP_DIFFERENCE_WITH_BORROW_RR, OP_DIFFERENCE_NO_FLAGS_RR};
	// Attributes: subtract, extension, carry in, writes, flags
	localparam logic [5:0] ATT [13] = '{6'h0A, 6'h12, 6'h02, 6'h0B, 6'h13, 6'h03, 6'h07,
		6'h29, 6'h31, 6'h21, 6'h23, 6'h27, 6'h22};
	initial begin
		logic [31:0] d;
		logic [1:0] rs;
		int n;
		repeat (6) @(posedge aclk);
		aresetn <= 1;
		@(posedge aclk);
		axr(ADDR_FLAGS, d, rs);
		chk("flags_rst", 32'h0000_0000, d);
		axr(ADDR_REGS + 8'h3C, d, rs);
		chk("r15_rst", 32'h0000_0000, d);
		axr(8'h20, d, rs);
		chk("unmapped", {30'h0, RESP_SLVERR}, {d[31:2], rs});
		for (int s = 0; s < 2; s++) begin
			for (int k = 0; k < 13; k++) begin
				op_case(OPS[k], ATT[k], s ? 32'h8000_0009 : 32'h7FFF_FFF8, s ? 4'h0 : 4'hF);
			end
		end
		chk("imm_s5", 32'h0000_0009, {27'h0, imm_s5});
		chk("imm_s10", 32'hFFFF_FE4C, imm_s10);
		chk("disp_u6", 32'h0000_0024, disp_u6);
		chk("dir_addr10", 32'h0000_024C, dir_addr10);
		chk("branch_off9", 32'hFFFF_FF26, br9);
		hz(32'h0000_0031, 2);
		hz(32'h0000_0051, 1);
		hz(32'h0000_0002, 2);
		hz(32'h0000_0004, 2);
		axw(ADDR_REGS + 8'h34, 32'h0000_0010, rs);
		exec({OP_MDREG_HI, 8'h93}, n);
		chk("alias_cycles", 1, n);
		axr(ADDR_REGS + 8'h34, d, rs);
		chk("alias_r13", 32'h8000_0019, d);
		slow <= 1;
		exec({OP_ADD_RR, 8'h93}, n);
		chk("slow_mem", 1, n > 1);
		axw(ADDR_INSTR, {16'h0, OP_ADD_RR, 8'h93}, rs);
		axw(ADDR_INSTR, {16'h0, OP_ADD_RR, 8'h93}, rs);
		chk("busy_refuse", {30'h0, RESP_SLVERR}, {30'h0, rs});
		slow <= 0;
		close_out();
	end
endmodule // add_sub_compare_unit_tb
